/* File: common/tap_params.svh */
// Purpose: constants of the test access port block
// Assumes: included by bare name
// Notes: instruction codes are four bits wide
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

// ****************************************
// instruction codes
// ****************************************
`define IR_W 4
`define IR_EXTEST 4'h0
`define IR_SAMPRE 4'h1
`define IR_IDREAD 4'h2
`define IR_SELFTEST 4'h7
`define IR_FLOAT_ALL 4'h8
`define IR_BYPASS 4'hF
// fixed pattern loaded in capture of the instruction path
`define IR_CAPTURE 4'h1

// ****************************************
// data register sizes
// ****************************************
`define ID_W 32

`endif

/* File: common/tap_pkg.sv */
// Purpose: types shared by the test access port files
// Assumes: nothing
// Notes: tap states follow the usual sixteen-state order
package tap_pkg;

  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_e;

  // ****************************************
  // pins from the board tester
  // ****************************************
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtag_pins_s;

endpackage : tap_pkg

/* File: hdl/sync2.sv */
// Purpose: two-flop synchroniser for a bus of independent levels
// Assumes: each bit is a level, no word coherence needed
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s r_r;
  sync_s r_nxt;

  // shift one stage per clock
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
  end

  // reset to the idle level of each pin
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      r_r <= {INIT, INIT};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.s2;

endmodule : sync2
`default_nettype wire

/* File: hdl/tap_iso.sv */
// Purpose: test access port with pin isolation mode
// Assumes: tck, tms, tdi, trst_n and pins sampled by mclk
// Notes: tck must be slower than mclk/4; edges found by sampling
`include "tap_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tap_iso
  import tap_pkg::*;
#(
  parameter int BSR_LEN = 8,
  parameter logic [`ID_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire jtag_pins_s jtag,
  output logic tdo_o,
  output logic tdo_oe_n,
  input wire logic reset_n_pin,
  input wire logic lock_in,
  output logic lock_o,
  output logic lock_oe_n,
  input wire logic core_lock,
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic [BSR_LEN-1:0] core_out,
  input wire logic [BSR_LEN-1:0] core_oe_n,
  output logic [BSR_LEN-1:0] pin_out,
  output logic [BSR_LEN-1:0] pin_oe_n,
  input wire logic bist_pass,
  output logic bist_run,
  output logic core_hold,
  output logic iso_mode,
  output logic pullup_en
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (BSR_LEN < 1 || BSR_LEN > 1024) begin : g_chk
    $error("BSR_LEN out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic tck_d;
    logic rst_d;
    tap_state_e st;
    logic [`IR_W-1:0] ir_sh;
    logic [`IR_W-1:0] ir;
    logic [`ID_W-1:0] dr_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_up;
    logic tdo;
    logic tdo_oe_n;
    logic iso;
    logic lock_o;
    logic lock_oe_n;
    logic [BSR_LEN-1:0] pin_out;
    logic [BSR_LEN-1:0] pin_oe_n;
    logic bist_run;
    logic core_hold;
    logic pu_en;
  } tap_s;

  tap_s r_r;
  tap_s r_nxt;

  localparam int SW = 6 + BSR_LEN;
  localparam logic [SW-1:0] SYNC_INIT = {6'b0111_01, {BSR_LEN{1'b0}}};

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s;
  logic rst_s;
  logic lock_s;
  logic [BSR_LEN-1:0] pin_s;
  logic rise;
  logic fall;
  logic sel_id;
  logic sel_bist;
  logic sel_bsr;
  logic extest;

  // ****************************************
  // input synchronisers
  // ****************************************
  // every pin from the tester or board is two-flopped before use
  sync2 #(
    .W(SW),
    .INIT(SYNC_INIT)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d({jtag.tck, jtag.tms, jtag.tdi, jtag.trst_n, reset_n_pin,
        lock_in, pin_in}),
    .q({tck_s, tms_s, tdi_s, trst_s, rst_s, lock_s, pin_s})
  );

  // tck edges found against last sample; no edge means no change
  assign rise = tck_s & ~r_r.tck_d;
  assign fall = ~tck_s & r_r.tck_d;

  // ****************************************
  // instruction decode
  // ****************************************
  // anything not naming a register falls back to bypass
  always_comb begin
    sel_id = (r_r.ir == `IR_IDREAD);
    sel_bist = (r_r.ir == `IR_SELFTEST);
    extest = (r_r.ir == `IR_EXTEST);
    sel_bsr = extest | (r_r.ir == `IR_SAMPRE);
  end

  // standard diagram, one step per rising tck
  function automatic tap_state_e tap_next(tap_state_e s, logic m);
    tap_state_e n;
    n = s;
    case (s)
      TLR: n = m ? TLR : RTI;
      RTI: n = m ? SEL_DR : RTI;
      SEL_DR: n = m ? SEL_IR : CAP_DR;
      CAP_DR: n = m ? EX1_DR : SH_DR;
      SH_DR: n = m ? EX1_DR : SH_DR;
      EX1_DR: n = m ? UPD_DR : PA_DR;
      PA_DR: n = m ? EX2_DR : PA_DR;
      EX2_DR: n = m ? UPD_DR : SH_DR;
      UPD_DR: n = m ? SEL_DR : RTI;
      SEL_IR: n = m ? TLR : CAP_IR;
      CAP_IR: n = m ? EX1_IR : SH_IR;
      SH_IR: n = m ? EX1_IR : SH_IR;
      EX1_IR: n = m ? UPD_IR : PA_IR;
      PA_IR: n = m ? EX2_IR : PA_IR;
      EX2_IR: n = m ? UPD_IR : SH_IR;
      UPD_IR: n = m ? SEL_DR : RTI;
      default: n = TLR;
    endcase
    return n;
  endfunction : tap_next

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    r_nxt = r_r;
    r_nxt.tck_d = tck_s;
    r_nxt.rst_d = rst_s;
    // rising tck: step controller, capture and shift
    if (rise) begin
      r_nxt.st = tap_next(r_r.st, tms_s);
      case (r_r.st)
        CAP_IR: begin
          r_nxt.ir_sh = `IR_CAPTURE;
        end
        SH_IR: begin
          r_nxt.ir_sh = {tdi_s, r_r.ir_sh[`IR_W-1:1]};
        end
        CAP_DR: begin
          if (sel_bsr) begin
            r_nxt.bsr_sh = pin_s;
          end else if (sel_id) begin
            r_nxt.dr_sh = ID_CODE;
          end else if (sel_bist) begin
            r_nxt.dr_sh = {{(`ID_W-1){1'b0}}, bist_pass};
          end else begin
            r_nxt.dr_sh = '0;
          end
        end
        SH_DR: begin
          // only the selected path moves toward tdo
          if (sel_bsr) begin
            r_nxt.bsr_sh = {tdi_s, r_r.bsr_sh[BSR_LEN-1:1]};
          end else if (sel_id) begin
            r_nxt.dr_sh = {tdi_s, r_r.dr_sh[`ID_W-1:1]};
          end else begin
            r_nxt.dr_sh[0] = tdi_s;
          end
        end
        default: begin
        end
      endcase
    end
    // falling tck: drive tdo and apply updates
    if (fall) begin
      case (r_r.st)
        SH_IR: begin
          r_nxt.tdo = r_r.ir_sh[0];
          r_nxt.tdo_oe_n = 1'b0;
        end
        SH_DR: begin
          r_nxt.tdo = sel_bsr ? r_r.bsr_sh[0] : r_r.dr_sh[0];
          r_nxt.tdo_oe_n = 1'b0;
        end
        UPD_IR: begin
          // new code replaces old; float-all isolation and self-test core hold stay set until a system reset
          r_nxt.ir = r_r.ir_sh;
          r_nxt.tdo_oe_n = 1'b1;
          if (r_r.ir_sh == `IR_FLOAT_ALL) begin
            r_nxt.iso = 1'b1;
          end
        end
        UPD_DR: begin
          if (sel_bsr) begin
            r_nxt.bsr_up = r_r.bsr_sh;
          end
          r_nxt.tdo_oe_n = 1'b1;
        end
        TLR: begin
          r_nxt.ir = `IR_IDREAD;
          r_nxt.tdo_oe_n = 1'b1;
        end
        default: begin
          r_nxt.tdo_oe_n = 1'b1;
        end
      endcase
    end
    // trst overrides tck activity on state, ir and tdo enable
    if (!trst_s) begin
      r_nxt.st = TLR;
      r_nxt.ir = `IR_IDREAD;
      r_nxt.tdo_oe_n = 1'b1;
    end
    // self-test holds the core until a system reset with another code in ir
    r_nxt.bist_run = (r_nxt.ir == `IR_SELFTEST);
    if (r_nxt.bist_run) begin
      r_nxt.core_hold = 1'b1;
    end
    // lock pin latched as reset rises; high exits, low enters
    // a float-all code landing in the same cycle wins unless isolation was already set
    if (rst_s && !r_r.rst_d) begin
      r_nxt.iso = ~lock_s | (r_nxt.iso & ~r_r.iso);
      r_nxt.core_hold = r_nxt.bist_run;
    end
    // pin drivers follow the registered mode
    r_nxt.lock_o = core_lock;
    r_nxt.lock_oe_n = ~(rst_s & ~r_nxt.iso);
    r_nxt.pin_out = extest ? r_r.bsr_up : core_out;
    r_nxt.pin_oe_n = r_nxt.iso ? '1 : (extest ? '0 : core_oe_n);
    r_nxt.pu_en = ~r_nxt.iso;
  end

  // ****************************************
  // state register
  // ****************************************
  // controller and shift registers hold when tck is still; trst, the reset pin and pin drivers act without tck edges
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      r_r <= '0;
      r_r.st <= TLR;
      r_r.ir <= `IR_IDREAD;
      r_r.tdo_oe_n <= 1'b1;
      r_r.lock_oe_n <= 1'b1;
      r_r.pin_oe_n <= '1;
      r_r.pu_en <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from flops
  assign tdo_o = r_r.tdo;
  assign tdo_oe_n = r_r.tdo_oe_n;
  assign lock_o = r_r.lock_o;
  assign lock_oe_n = r_r.lock_oe_n;
  assign pin_out = r_r.pin_out;
  assign pin_oe_n = r_r.pin_oe_n;
  assign bist_run = r_r.bist_run;
  assign core_hold = r_r.core_hold;
  assign iso_mode = r_r.iso;
  assign pullup_en = r_r.pu_en;

  // ****************************************
  // assertions
  // ****************************************
  a_trst_to_tlr: assert property (@(posedge mclk) disable iff (!rstn)
    !trst_s |=> r_r.st == TLR && r_r.ir == `IR_IDREAD)
    else $error("trst did not reset controller");

  a_tlr_loads_id: assert property (@(posedge mclk) disable iff (!rstn)
    fall && r_r.st == TLR |=> r_r.ir == `IR_IDREAD)
    else $error("test-logic-reset kept other code");

  a_hold_no_edge: assert property (@(posedge mclk) disable iff (!rstn)
    !rise && !fall && trst_s |=> $stable(r_r.st)
      && $stable(r_r.ir_sh) && $stable(r_r.dr_sh))
    else $error("state moved without tck edge");

  a_tdo_on_fall: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(tdo_o) |-> $past(fall))
    else $error("tdo changed off falling edge");

  a_tdo_float: assert property (@(posedge mclk) disable iff (!rstn)
    fall && r_r.st != SH_IR && r_r.st != SH_DR |=> tdo_oe_n)
    else $error("tdo driven outside shift");

  a_ir_capture: assert property (@(posedge mclk) disable iff (!rstn)
    rise && r_r.st == CAP_IR |=> r_r.ir_sh == `IR_CAPTURE)
    else $error("instruction capture pattern wrong");

  a_bypass_pass: assert property (@(posedge mclk) disable iff (!rstn)
    rise && r_r.st == SH_DR && r_r.ir == `IR_BYPASS
      |=> r_r.dr_sh[0] == $past(tdi_s))
    else $error("bypass stage lost data");

  a_iso_enter: assert property (@(posedge mclk) disable iff (!rstn)
    rst_s && !r_r.rst_d && !lock_s |=> iso_mode ##1 &pin_oe_n
      && !pullup_en)
    else $error("isolation not entered at reset");

  a_iso_exit: assert property (@(posedge mclk) disable iff (!rstn)
    rst_s && !r_r.rst_d && lock_s |=> !iso_mode)
    else $error("isolation not left at reset");

  a_float_instr: assert property (@(posedge mclk) disable iff (!rstn)
    fall && r_r.st == UPD_IR && r_r.ir_sh == `IR_FLOAT_ALL
      && trst_s |=> iso_mode)
    else $error("float-all code ignored");

  a_lock_input: assert property (@(posedge mclk) disable iff (!rstn)
    !rst_s |=> lock_oe_n)
    else $error("lock pin driven in reset");

endmodule : tap_iso
`default_nettype wire

/* File: verification/jtag_tester.sv */
// Purpose: board tester model driving the test port pins
// Assumes: tck idles low between scans; trst_n pulled high
// Notes: tck high phase stretched at random to stall the port
`timescale 1ns/1ps
`default_nettype none
module jtag_tester
  import tap_pkg::*;
(
  output var jtag_pins_s jtag,
  input wire logic tdo_o,
  input wire logic tdo_oe_n
);
  // idle: tms/tdi/trst_n resolve to their pull-up level
  initial jtag = '{1'b0, 1'b1, 1'b1, 1'b1};
  // one tck period; tdo read just before the rise
  task automatic step(input logic ms, input logic di, output logic b);
    jtag.tms = ms;
    jtag.tdi = di;
    #160;
    b = (tdo_oe_n === 1'b0) ? tdo_o : 1'bz;
    jtag.tck = 1'b1;
    #(160 + 320 * ($urandom % 3));
    jtag.tck = 1'b0;
  endtask : step
  // walk n tms bits, lsb first, then shift len bits and go idle
  task automatic scan(input logic [7:0] ts, input int n, input int len,
                      input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(ts[i], 1'b0, b);
    end
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], b);
      dout[i] = b;
    end
    if (len > 0) begin
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
    end
  endtask : scan
  // asynchronous test reset pulse, no tck edge
  task automatic pulse_trst();
    jtag.trst_n = 1'b0;
    #200;
    jtag.trst_n = 1'b1;
  endtask : pulse_trst
endmodule : jtag_tester
`default_nettype wire

/* File: verification/tap_iso_test.sv */
// Purpose: self-checking bench of the test port with isolation
// Assumes: tester model owns the tck domain
// Notes: seed 43; expectations from instruction constants
`include "tap_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tap_iso_test
  import tap_pkg::*;
;
  localparam logic [31:0] ID_V = 32'h5A3C_0F01; // arbitrary
  logic mclk = 1'b0, rstn, tdo_o, tdo_oe_n, reset_n_pin, lock_in, lock_o;
  logic lock_oe_n, core_lock, bist_pass, bist_run, core_hold, iso_mode;
  logic pullup_en;
  logic [7:0] pin_in, core_out, core_oe_n, pin_out, pin_oe_n;
  logic [31:0] d, r;
  jtag_pins_s jtag;
  int n_mismatch = 0, checked = 0;
  logic [3:0] codes [8] = '{4'hF, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA, 4'hD, 4'hE};
  // ****************************************
  // clock, design and tester
  // ****************************************
  always #20 mclk = ~mclk;
  tap_iso #(.BSR_LEN(8), .ID_CODE(ID_V)) dut (.mclk(mclk), .rstn(rstn),
    .jtag(jtag), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n),
    .reset_n_pin(reset_n_pin), .lock_in(lock_in), .lock_o(lock_o),
    .lock_oe_n(lock_oe_n), .core_lock(core_lock), .pin_in(pin_in),
    .core_out(core_out), .core_oe_n(core_oe_n), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .bist_pass(bist_pass), .bist_run(bist_run),
    .core_hold(core_hold), .iso_mode(iso_mode), .pullup_en(pullup_en));
  jtag_tester tester (.jtag(jtag), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n));
  // ****************************************
  // checking tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // bounded wait on the isolation flag; a hang ends the run
  task automatic wait_iso(input logic v);
    int k;
    k = 0;
    while (iso_mode !== v && k < 20) begin
      @(negedge mclk);
      k++;
    end
    chk("iso_mode", iso_mode, v);
    // only a flag that never arrived ends the run here
    if (iso_mode !== v) complete_run();
  endtask : wait_iso
  // system reset cycle with the lock pin held at lk
  task automatic pin_reset(input logic lk);
    @(posedge mclk);
    reset_n_pin <= 1'b0;
    lock_in <= lk;
    repeat (4) @(negedge mclk);
    chk("lock_oe_n", lock_oe_n, 1);
    @(posedge mclk);
    reset_n_pin <= 1'b1;
    wait_iso(~lk);
    // lock driver follows the synchronised pin one cycle late
    repeat (4) @(negedge mclk);
  endtask : pin_reset
  task automatic ir(input logic [3:0] c);
    tester.scan(8'h03, 4, 4, {28'h0, c}, d);
    chk("ir_capture", d, 4'h1);
  endtask : ir
  task automatic dr(input int len, input logic [31:0] din);
    tester.scan(8'h01, 3, len, din, d);
  endtask : dr
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    r = $urandom(43);
    {rstn, reset_n_pin, core_lock, bist_pass} <= 4'h0;
    {lock_in, pin_in, core_out, core_oe_n} <= {1'b1, 24'h0000FF};
    repeat (10) @(negedge mclk);
    chk("reset_out", {tdo_oe_n, lock_oe_n, pullup_en, iso_mode, pin_oe_n},
        12'hEFF);
    @(posedge mclk);
    rstn <= 1'b1;
    core_lock <= 1'b1;
    pin_reset(1'b1);
    chk("lock_out", {lock_oe_n, lock_o}, 2'b01);
    $display("test reset done");
    tester.scan(8'h00, 1, 0, 0, d);
    // unused codes and bypass all take the one-stage path
    foreach (codes[i]) begin
      ir(codes[i]);
      repeat (4) @(negedge mclk);
      chk("tdo_idle", tdo_oe_n, 1);
      r = $urandom;
      dr(16, r);
      chk("bypass", d[15:0], {r[14:0], 1'b0});
    end
    $display("test bypass done");
    tester.scan(8'h1F, 6, 0, 0, d);
    repeat (2) begin
      dr(32, $urandom);
      chk("idcode", d, ID_V);
    end
    $display("test idcode done");
    @(posedge mclk);
    bist_pass <= r[3];
    // keep tester edges off the sampling edge
    @(negedge mclk);
    ir(`IR_SELFTEST);
    dr(1, 0);
    chk("selftest", {bist_run, core_hold, d[0]}, {2'b11, r[3]});
    @(posedge mclk);
    pin_in <= r[11:4];
    @(negedge mclk);
    ir(`IR_SAMPRE);
    dr(8, r[23:16]);
    chk("sample", d[7:0], r[11:4]);
    ir(`IR_EXTEST);
    dr(8, r[31:24]);
    repeat (4) @(negedge mclk);
    chk("extest", {d[7:0], pin_oe_n, pin_out},
        {r[11:4], 8'h00, r[31:24]});
    $display("test boundary done");
    ir(`IR_BYPASS);
    tester.scan(8'h01, 5, 0, 0, d);
    tester.pulse_trst();
    tester.scan(8'h00, 1, 0, 0, d);
    dr(32, 0);
    chk("trst_id", d, ID_V);
    $display("test trst done");
    ir(`IR_FLOAT_ALL);
    wait_iso(1'b1);
    repeat (2) @(negedge mclk);
    chk("float", {pullup_en, lock_oe_n, pin_oe_n}, 10'h1FF);
    pin_reset(1'b1);
    chk("resume", {pullup_en, core_hold, pin_oe_n}, 10'h2FF);
    pin_reset(1'b0);
    chk("lock_float", {pullup_en, pin_oe_n}, 9'h0FF);
    pin_reset(1'b1);
    $display("test isolation done");
    complete_run();
  end
endmodule : tap_iso_test
`default_nettype wire
